// ---- rqp_pkg.sv ----
// Purpose: Constants and types for the per-phase reactive power datapath
// Assumes: Samples arrive at 8 kHz on a 100 MHz mclk
// Notes: Register offsets are local choices for the internal register port
//
// Contract
// - Instantaneous reactive power is voltage times ninety-degree shifted current, per phase.
// - All harmonic content kept; three phases computed independently.
// - Publish 24-bit signed power, full scale equals power constant over sixteen.
// - Each phase has a 24-bit signed gain spanning plus or minus 100 percent.
// - Output equals filtered power times one plus gain over two to 23.
// - Gain C00000 halves output; gain 400000 raises it by half.
// - Each phase has a 24-bit signed offset nulling no-load power.
// - Gain and offset carried as 32-bit words, sign extended to 28 bits.
// - Sign evaluated at 48-bit threshold crossing; change flagged against previous sign.
// - Sign change on C, B, A sets status bits 12, 11, 10.
// - Sign bits 6, 5, 4 update in the same cycle as status.
// - Sign bit reads 0 when positive, 1 when negative.
// - Enabled mask bits 12..10 drive the active-low interrupt low on change.
// - Writing one clears a status bit and releases the interrupt.
// - Phase 0..+90 gives positive power, -90..0 negative, integrator on or off.
// - Accumulate every 125 us, pulse at threshold, then subtract threshold.
// - Threshold is 48-bit signed, host keeps it non-negative.
package rqp_pkg;
    // ==========================================================
    // Register offsets (word index on the internal register port)
    localparam logic [3:0] OFS_INST_A = 4'h0;
    localparam logic [3:0] OFS_INST_B = 4'h1;
    localparam logic [3:0] OFS_INST_C = 4'h2;
    localparam logic [3:0] OFS_GAIN_A = 4'h3;
    localparam logic [3:0] OFS_GAIN_B = 4'h4;
    localparam logic [3:0] OFS_GAIN_C = 4'h5;
    localparam logic [3:0] OFS_OFFS_A = 4'h6;
    localparam logic [3:0] OFS_OFFS_B = 4'h7;
    localparam logic [3:0] OFS_OFFS_C = 4'h8;
    localparam logic [3:0] OFS_SIGN = 4'h9;
    localparam logic [3:0] OFS_STATUS = 4'hA;
    localparam logic [3:0] OFS_MASK = 4'hB;
    localparam logic [3:0] OFS_THR_LO = 4'hC;
    localparam logic [3:0] OFS_THR_HI = 4'hD;
    // ==========================================================
    // Field positions
    localparam int STAT_BIT_A = 10;
    localparam int SIGN_BIT_A = 4;
    localparam int PHASES = 3;
    // ==========================================================
    // Reset values
    localparam logic [23:0] GAIN_RST = 24'h000000;
    localparam logic [23:0] OFFS_RST = 24'h000000;
    localparam logic [47:0] THR_RST = 48'h000001FF6A6B;
    localparam logic [31:0] MASK_RST = 32'h00000000;
    // ==========================================================
    // Timing: sample period and its cycle count
    localparam int CLK_HZ = 100000000;
    localparam int SAMPLE_HZ = 8000;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam logic [13:0] SAMPLE_LAST = 14'(SAMPLE_CYC - 1);
    // Fixed product shift: 24x24 product to 24-bit word scaled by 1/16
    localparam int PROD_SHIFT = 27;
    // ==========================================================
    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } rqp_req_type;
    // Per-phase samples: voltage and 90-degree shifted current
    typedef struct packed {
        logic signed [23:0] volt;
        logic signed [23:0] curr_q;
    } rqp_sample_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALC = 2'b10
    } rqp_state_type;
endpackage

// ---- rqp_datapath.sv ----
// Purpose: Per-phase reactive power, gain, offset, sign-change detection
// Assumes: Shifted currents arrive already rotated by ninety degrees
// Notes: One phase-step pipeline, three phases processed in parallel
`timescale 1ns/1ps
module rqp_datapath (
    input wire logic mclk,
    input wire logic rst,
    input wire rqp_pkg::rqp_sample_type samp_a,
    input wire rqp_pkg::rqp_sample_type samp_b,
    input wire rqp_pkg::rqp_sample_type samp_c,
    input wire rqp_pkg::rqp_req_type req,
    output logic [31:0] rdata,
    output logic sample_strobe,
    output logic [2:0] energy_pulse,
    output logic irq_line_primary_n
);
    import rqp_pkg::*;

    // ==========================================================
    // Register storage
    logic [13:0] tick_r;
    logic [23:0] gain_r [PHASES];
    logic [23:0] offs_r [PHASES];
    logic [23:0] inst_r [PHASES];
    logic signed [47:0] acc_r [PHASES];
    logic [47:0] thr_r;
    logic [2:0] stat_r;
    logic [2:0] sign_r;
    logic [2:0] mask_r;
    logic [2:0] pulse_r;
    logic [2:0] chg;
    logic [2:0] new_sign;
    logic signed [47:0] acc_nxt [PHASES];
    logic signed [23:0] q_pw [PHASES];
    logic tick_hit;
    logic [2:0] wr_stat_clr;

    // ==========================================================
    // 125 us sample tick
    assign tick_hit = (tick_r == SAMPLE_LAST);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_r <= 14'h0000;
        end else if (tick_hit) begin
            tick_r <= 14'h0000;
        end else begin
            tick_r <= tick_r + 14'h0001;
        end
    end

    // ==========================================================
    // Per-phase arithmetic
    function automatic logic signed [23:0] sat24(input logic signed [49:0] v);
        if (v > 50'sh0_0000_007F_FFFF) begin
            sat24 = 24'sh7FFFFF;
        end else if (v < -50'sh0_0000_0080_0000) begin
            sat24 = 24'sh800000;
        end else begin
            sat24 = v[23:0];
        end
    endfunction

    // Product, offset, gain: the offset goes in before gain so gain trims
    // the corrected value, not the raw crosstalk term
    function automatic logic signed [23:0] calc_q(
        input rqp_sample_type s,
        input logic signed [23:0] ofs,
        input logic signed [23:0] gn
    );
        logic signed [47:0] prod;
        logic signed [23:0] raw;
        logic signed [23:0] cor;
        logic signed [49:0] scaled;
        prod = s.volt * s.curr_q;
        raw = sat24(50'(prod >>> PROD_SHIFT));
        cor = sat24(50'(raw) + 50'(ofs));
        scaled = 50'(cor) + ((50'(cor) * 50'(gn)) >>> 23);
        calc_q = sat24(scaled);
    endfunction

    // Positive angle gives positive product, no sign fix-up needed
    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            q_pw[p] = '0;
        end
        q_pw[0] = calc_q(samp_a, offs_r[0], gain_r[0]);
        q_pw[1] = calc_q(samp_b, offs_r[1], gain_r[1]);
        q_pw[2] = calc_q(samp_c, offs_r[2], gain_r[2]);
    end

    // Published instantaneous words latch once per sample
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < PHASES; p++) begin
                inst_r[p] <= 24'h000000;
            end
        end else if (tick_hit) begin
            for (int p = 0; p < PHASES; p++) begin
                inst_r[p] <= q_pw[p];
            end
        end
    end

    // ==========================================================
    // First-stage accumulation and sign detection
    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            acc_nxt[p] = acc_r[p] + 48'(q_pw[p]);
            chg[p] = 1'b0;
            new_sign[p] = sign_r[p];
            pulse_r[p] = 1'b0;
        end
        for (int p = 0; p < PHASES; p++) begin
            if (tick_hit && acc_nxt[p] >= $signed(thr_r)) begin
                pulse_r[p] = 1'b1;
                new_sign[p] = 1'b0;
            end else if (tick_hit && acc_nxt[p] <= -$signed(thr_r)) begin
                pulse_r[p] = 1'b1;
                new_sign[p] = 1'b1;
            end
            chg[p] = pulse_r[p] && (new_sign[p] != sign_r[p]);
        end
    end
    assign energy_pulse = pulse_r;
    assign sample_strobe = tick_hit;

    // Threshold subtracted in the direction of the crossing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < PHASES; p++) begin
                acc_r[p] <= 48'sh0;
            end
        end else if (tick_hit) begin
            for (int p = 0; p < PHASES; p++) begin
                if (pulse_r[p] && !new_sign[p]) begin
                    acc_r[p] <= acc_nxt[p] - $signed(thr_r);
                end else if (pulse_r[p]) begin
                    acc_r[p] <= acc_nxt[p] + $signed(thr_r);
                end else begin
                    acc_r[p] <= acc_nxt[p];
                end
            end
        end
    end

    // Sign bits update together with the status bits
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sign_r <= 3'h0;
        end else begin
            sign_r <= new_sign;
        end
    end

    // ==========================================================
    // Status, write-one-to-clear; a new change wins over a clear
    assign wr_stat_clr = (req.wr && req.addr == OFS_STATUS) ? req.wdata[STAT_BIT_A +: 3] : 3'h0;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat_r <= 3'h0;
        end else begin
            stat_r <= (stat_r & ~wr_stat_clr) | chg;
        end
    end

    // Interrupt low while any enabled flag stands
    assign irq_line_primary_n = ~|(stat_r & mask_r);

    // ==========================================================
    // Writable registers; upper bits of a written word are ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < PHASES; p++) begin
                gain_r[p] <= GAIN_RST;
                offs_r[p] <= OFFS_RST;
            end
            mask_r <= MASK_RST[STAT_BIT_A +: 3];
            thr_r <= THR_RST;
        end else if (req.wr) begin
            if (req.addr == OFS_GAIN_A) begin
                gain_r[0] <= req.wdata[23:0];
            end else if (req.addr == OFS_GAIN_B) begin
                gain_r[1] <= req.wdata[23:0];
            end else if (req.addr == OFS_GAIN_C) begin
                gain_r[2] <= req.wdata[23:0];
            end else if (req.addr == OFS_OFFS_A) begin
                offs_r[0] <= req.wdata[23:0];
            end else if (req.addr == OFS_OFFS_B) begin
                offs_r[1] <= req.wdata[23:0];
            end else if (req.addr == OFS_OFFS_C) begin
                offs_r[2] <= req.wdata[23:0];
            end else if (req.addr == OFS_MASK) begin
                mask_r <= req.wdata[STAT_BIT_A +: 3];
            end else if (req.addr == OFS_THR_LO) begin
                thr_r[23:0] <= req.wdata[23:0];
            end else if (req.addr == OFS_THR_HI) begin
                thr_r[47:24] <= req.wdata[23:0];
            end
        end
    end

    // ==========================================================
    // Read path, registered; power, gain and offset words go out sign extended to 28, threshold halves zero padded
    function automatic logic [31:0] ext28(input logic [23:0] v);
        ext28 = {4'h0, {4{v[23]}}, v};
    endfunction

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (req.rd) begin
            if (req.addr == OFS_INST_A) begin
                rdata <= ext28(inst_r[0]);
            end else if (req.addr == OFS_INST_B) begin
                rdata <= ext28(inst_r[1]);
            end else if (req.addr == OFS_INST_C) begin
                rdata <= ext28(inst_r[2]);
            end else if (req.addr == OFS_GAIN_A) begin
                rdata <= ext28(gain_r[0]);
            end else if (req.addr == OFS_GAIN_B) begin
                rdata <= ext28(gain_r[1]);
            end else if (req.addr == OFS_GAIN_C) begin
                rdata <= ext28(gain_r[2]);
            end else if (req.addr == OFS_OFFS_A) begin
                rdata <= ext28(offs_r[0]);
            end else if (req.addr == OFS_OFFS_B) begin
                rdata <= ext28(offs_r[1]);
            end else if (req.addr == OFS_OFFS_C) begin
                rdata <= ext28(offs_r[2]);
            end else if (req.addr == OFS_SIGN) begin
                rdata <= 32'({sign_r, 4'h0});
            end else if (req.addr == OFS_STATUS) begin
                rdata <= 32'({stat_r, 10'h000});
            end else if (req.addr == OFS_MASK) begin
                rdata <= 32'({mask_r, 10'h000});
            end else if (req.addr == OFS_THR_LO) begin
                rdata <= {8'h00, thr_r[23:0]};
            end else if (req.addr == OFS_THR_HI) begin
                rdata <= {8'h00, thr_r[47:24]};
            end else begin
                rdata <= 32'h00000000;
            end
        end
    end
endmodule

// ---- rqp_checker.sv ----
// Purpose: Port-level checks of the reactive power datapath
// Assumes: One mclk domain, rst asynchronous and active high
// Notes: Bound to the design top after the module
`timescale 1ns/1ps
module rqp_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire rqp_pkg::rqp_req_type req,
    input wire logic [31:0] rdata,
    input wire logic sample_strobe,
    input wire logic [2:0] energy_pulse,
    input wire logic irq_line_primary_n
);
    import rqp_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [13:0] tick_cnt_r;
    logic [31:0] gain_a_r;
    // ==========================================================
    // Helpers: cycles since last tick, shadow of the last gain A write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 14'h0000;
        end else begin
            tick_cnt_r <= sample_strobe ? 14'h0000 : tick_cnt_r + 14'h0001;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gain_a_r <= 32'h00000000;
        end else if (req.wr && req.addr == OFS_GAIN_A) begin
            gain_a_r <= {4'h0, {4{req.wdata[23]}}, req.wdata[23:0]};
        end
    end
    // ==========================================================
    // Register reads, tick, pulse and interrupt behaviour
    sequence rd_at(logic [3:0] a);
        req.rd && req.addr == a;
    endsequence
    tick_period_a: assert property (sample_strobe |-> tick_cnt_r == SAMPLE_LAST)
        else $error("tick spacing wrong");
    tick_single_a: assert property (sample_strobe |=> !sample_strobe [*8])
        else $error("tick wider than one cycle");
    pulse_on_tick_a: assert property (|energy_pulse |-> sample_strobe || $past(sample_strobe))
        else $error("energy pulse away from tick");
    irq_fall_cause_a: assert property ($fell(irq_line_primary_n) |-> $past(sample_strobe) || $past(req.wr))
        else $error("irq fell without event or mask write");
    irq_rise_cause_a: assert property ($rose(irq_line_primary_n) |-> $past(req.wr))
        else $error("irq released without a write");
    unmapped_zero_a: assert property (req.rd && req.addr > OFS_THR_HI |=> rdata == 32'h00000000)
        else $error("unmapped read not zero");
    gain_readback_a: assert property (rd_at(OFS_GAIN_A) |=> rdata == gain_a_r)
        else $error("gain readback differs");
    inst_format_a: assert property (req.rd && req.addr <= OFS_INST_C |=> rdata[31:28] == 4'h0
        && (rdata[27:23] == 5'h00 || rdata[27:23] == 5'h1F)) else $error("inst word not sign extended");
    status_field_a: assert property (rd_at(OFS_STATUS) |=> (rdata & ~32'h00001C00) == 32'h0)
        else $error("status bits outside field");
    rdata_hold_a: assert property (!req.rd |=> $stable(rdata))
        else $error("read data moved without read");
endmodule
bind rqp_datapath rqp_checker chk_u (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
    .sample_strobe(sample_strobe), .energy_pulse(energy_pulse), .irq_line_primary_n(irq_line_primary_n));

// ---- rqp_host.sv ----
// Purpose: Host model driving the register port
// Assumes: Requests launched and released on rising mclk
// Notes: One idle cycle between requests keeps each strobe single
`timescale 1ns/1ps
module rqp_host (
    input wire logic mclk,
    output rqp_pkg::rqp_req_type req,
    input wire logic [31:0] rdata
);
    import rqp_pkg::*;
    initial req = '0;
    // Write: word held for the one taking edge, 32-bit padded form
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
        // Let the taking edge's register updates settle before the caller looks
        #1;
    endtask
    // Read: data taken once the registered answer has settled
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk);
        req <= '0;
        #1;
        d = rdata;
    endtask
    // Event service: status, then sign at once, then acknowledge
    task automatic service(output logic [31:0] st, output logic [31:0] sg);
        rd(OFS_STATUS, st);
        rd(OFS_SIGN, sg);
        wr(OFS_STATUS, st);
    endtask
endmodule

// ---- rqp_datapath_tb.sv ----
// Purpose: Directed test of the reactive power datapath
// Assumes: Fixed 12500-cycle tick, so two ticks set the run length
// Notes: Threshold is small so every tick evaluates the sign
`timescale 1ns/1ps
module rqp_datapath_tb;
    import rqp_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    rqp_sample_type samp_a = '0;
    rqp_sample_type samp_b = '0;
    rqp_sample_type samp_c = '0;
    rqp_req_type req;
    logic [31:0] rdata, d, st, sg;
    logic sample_strobe, irq_n;
    logic [2:0] energy_pulse;
    int fails = 0;
    int total_checks = 0;
    always #5 mclk = ~mclk;
    rqp_datapath dut_u (.mclk(mclk), .rst(rst), .samp_a(samp_a), .samp_b(samp_b), .samp_c(samp_c),
        .req(req), .rdata(rdata), .sample_strobe(sample_strobe), .energy_pulse(energy_pulse),
        .irq_line_primary_n(irq_n));
    rqp_host host_u (.mclk(mclk), .req(req), .rdata(rdata));
    // ==========================================================
    // Compare, verdict and tick wait
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Bounded wait past the next tick edge; a hang ends the run
    task automatic tick();
        int n;
        n = 0;
        while (sample_strobe !== 1'b1 && n < 13000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 13000) begin
            chk("tick wait", 32'h0, 32'h1);
            results();
        end
        @(posedge mclk);
        #1;
    endtask
    // ==========================================================
    // Main sequence: 2^22 * 2^22 gives 0x20000 on A and B, -0x20000 on C, before gain
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        samp_a <= {24'h400000, 24'h400000};
        samp_b <= {24'h400000, 24'h400000};
        samp_c <= {24'hC00000, 24'h400000};
        host_u.rd(OFS_MASK, d); chk("mask reset", d, 32'h0);
        host_u.rd(OFS_GAIN_B, d); chk("gain reset", d, 32'h0);
        host_u.rd(OFS_THR_HI, d); chk("thr hi reset", d, 32'h1);
        host_u.rd(4'hE, d); chk("unmapped", d, 32'h0);
        host_u.wr(OFS_GAIN_A, 32'h00400000);
        host_u.wr(OFS_GAIN_B, 32'h0FC00000);
        host_u.wr(OFS_THR_LO, 32'h00000100);
        host_u.wr(OFS_THR_HI, 32'h00000000);
        host_u.wr(OFS_MASK, 32'h00001000);
        host_u.rd(OFS_GAIN_B, d); chk("gain b", d, 32'h0FC00000);
        tick();
        host_u.rd(OFS_INST_A, d); chk("inst a", d, 32'h00030000);
        host_u.rd(OFS_INST_B, d); chk("inst b", d, 32'h00010000);
        host_u.rd(OFS_INST_C, d); chk("inst c", d, 32'h0FFE0000);
        chk("irq c", {31'h0, irq_n}, 32'h0);
        host_u.service(st, sg);
        chk("status c", st, 32'h00001000);
        chk("sign c", sg, 32'h00000040);
        chk("irq ack", {31'h0, irq_n}, 32'h1);
        // Offset pulls phase A negative; acc lands exactly on -threshold
        host_u.wr(OFS_OFFS_A, 32'h0FFC0000);
        tick();
        host_u.rd(OFS_INST_A, d); chk("inst a ofs", d, 32'h0FFD0000);
        chk("irq masked", {31'h0, irq_n}, 32'h1);
        host_u.wr(OFS_MASK, 32'h00001C00);
        chk("irq held", {31'h0, irq_n}, 32'h0);
        host_u.service(st, sg);
        chk("status a", st, 32'h00000400);
        chk("sign a", sg, 32'h00000050);
        chk("irq clear", {31'h0, irq_n}, 32'h1);
        results();
    end
endmodule
